// ===== rtl/ncir_regs.sv
// Host command, interrupt status and interrupt mask registers of the network controller
// Functional notes
// - Restart go pulses resume, clears underrun, reads 0
// - Rx halt pulses, clears rx pending, reads 0
// - Tx halt pulses, clears tx pending, reads 0
// - Copy-done set by host, cleared at descriptor read
// - Rx pending queues, clears rx queue-empty flag
// - Tx pending queues, clears tx queue-empty flag
// - Online/offline writes set a persisting receiver state
// - Target and master abort flags latch
// - Parity flags latch only with parity response on
// - Three read-only state flags raise no interrupt
// - Copy-active flags span copy start to posting
// - Quiet flags show network and DMA idle
// - Pending-any shows unmasked set status bits
// - Phy pin event latches while pin low
// - Wake event clears only from power control write
// - Bus error summary ORs four error flags
// - Threshold, early receive and counter flags latch
// - Underrun flag; manual clears leave command bits
// - Three transmit event flags latch
// - Five receive event flags latch
// - Mask bits 15..0 gate interrupts, reset zero
// - Enabled unmasked status drives interrupt low
`timescale 1ns/1ps
`include "ncir_consts.svh"
module ncir_regs
	import ncir_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// Register access port
	input  wire logic [7:0]  regAddr,
	input  wire logic        regWr,
	input  wire logic        regRd,
	input  wire logic [31:0] regWdata,
	output logic [31:0]      regRdata,
	// Mode inputs from configuration and general control
	input  wire logic        regTestMode,
	input  wire logic        intEnable,
	input  wire logic        parityRespEn,
	input  wire logic        monitorMode,
	// Descriptor fetch events from the DMA engines
	input  wire logic        rxDescRead,
	input  wire logic        rxDescHostOwned,
	input  wire logic        txDescHostOwned,
	// Bus error events
	input  wire logic        evTargetAbort,
	input  wire logic        evMasterAbort,
	input  wire logic        evAddrParity,
	input  wire logic        evDataParity,
	input  wire logic        busMaster,
	// Receive and transmit state levels
	input  wire logic        rxStatusValid,
	input  wire logic        copyThreshState,
	input  wire logic        rxBufferEmpty,
	input  wire logic        transmit_quiet,
	input  wire logic        receive_quiet,
	// Copy progress pulses
	input  wire logic        txCopyStart,
	input  wire logic        txCopyPosted,
	input  wire logic        rxCopyStart,
	input  wire logic        rxCopyPosted,
	// Power management events
	input  wire logic        wakeSet,
	input  wire logic        wakeClear,
	// General purpose pin 2, asynchronous
	input  wire logic        gpio2Pin,
	// Latched event pulses
	input  wire logic        evCopyThresh,
	input  wire logic        evEarlyRx,
	input  wire logic        evCounterNear,
	input  wire logic        evTxUnderrun,
	input  wire logic        evTxChainDone,
	input  wire logic        evTxFrameDone,
	input  wire logic        evRxCrc,
	input  wire logic        evOverflow,
	input  wire logic        evHeaderCopy,
	input  wire logic        evRxCopy,
	// Command outputs to DMA and MAC
	output logic             transmitRestart,
	output logic             rxDmaHalt,
	output logic             txDmaHalt,
	output logic             frameCopyDone,
	output logic             rxDescPending,
	output logic             txDescPending,
	output logic             receiverOnline,
	// Interrupt line, open drain, active low
	output logic             intaOut,
	output logic             intaOe_n
);

	// ************************************************************
	// Declarations
	// ************************************************************
	ncir_sel_t              regSel;        // Decoded register
	logic                   cmdWr;         // Write to host command
	logic                   stWr;          // Write to interrupt status
	logic                   maskWr;        // Write to interrupt mask
	logic [15:0]            intMask;       // Interrupt enables
	logic [3:0]             busErr;        // Abort and parity flags 27..24
	logic [11:0]            evFlags;       // Latched event flags 11..0
	logic                   phyPinEvent;   // Latched pin event
	logic                   wakeEvent;     // Power management event
	logic                   txCopyActive;  // Transmit copy in progress
	logic                   rxCopyActive;  // Receive copy in progress
	logic [3:0]             busErrSet;     // Bus error set terms
	logic [11:0]            evSet;         // Event set terms
	logic [11:0]            evClr;         // Event clear terms
	logic [11:0]            next_evFlags;  // Event flags next value
	logic                   busErrorSummary;
	logic [15:0]            statusLow;     // Maskable status bits
	logic                   irqPendingAny;
	logic                   gpio2Low;      // Synchronised pin is low
	ncir_word_t             cmdRead;       // Host command read view
	ncir_word_t             statusRead;    // Interrupt status read view
	ncir_word_t             maskRead;      // Interrupt mask read view
	ncir_word_t             next_regRdata; // Selected read data
	logic                   restartWr;     // One written to restart go
	logic                   rxHaltWr;      // One written to rx halt
	logic                   txHaltWr;      // One written to tx halt
	logic                   rxQueueWr;     // One written to rx pending
	logic                   txQueueWr;     // One written to tx pending

	// ************************************************************
	// Pin synchroniser
	// ************************************************************
	ncir_sync_if #(.WIDTH(1)) pinIf ();
	assign pinIf.raw = gpio2Pin;

	ncir_sync #(.WIDTH(1)) u_pinSync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.port    (pinIf.sync)
	);

	assign gpio2Low = ~pinIf.synced[0];

	// ************************************************************
	// Address decode
	// ************************************************************
	assign regSel = (regAddr == `NCIR_OFS_HOST_COMMAND)     ? NCIR_SEL_COMMAND :
	                (regAddr == `NCIR_OFS_INTERRUPT_STATUS) ? NCIR_SEL_STATUS  :
	                (regAddr == `NCIR_OFS_INTERRUPT_MASK)   ? NCIR_SEL_MASK    :
	                                                          NCIR_SEL_NONE;
	assign cmdWr  = regWr && (regSel == NCIR_SEL_COMMAND);
	assign stWr   = regWr && (regSel == NCIR_SEL_STATUS);
	assign maskWr = regWr && (regSel == NCIR_SEL_MASK);

	// Command bits written with one (upper bits ignored)
	assign restartWr = cmdWr && regWdata[`NCIR_CMD_TX_RESTART_GO];
	assign rxHaltWr  = cmdWr && regWdata[`NCIR_CMD_RX_DMA_HALT];
	assign txHaltWr  = cmdWr && regWdata[`NCIR_CMD_TX_DMA_HALT];
	assign rxQueueWr = cmdWr && regWdata[`NCIR_CMD_RX_DESC_PENDING];
	assign txQueueWr = cmdWr && regWdata[`NCIR_CMD_TX_DESC_PENDING];

	// ************************************************************
	// Host command one-shot outputs, one cycle after the write
	// ************************************************************
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			transmitRestart <= 1'b0;
			rxDmaHalt       <= 1'b0;
			txDmaHalt       <= 1'b0;
		end else begin
			transmitRestart <= restartWr;
			rxDmaHalt       <= rxHaltWr;
			txDmaHalt       <= txHaltWr;
		end
	end

	// ************************************************************
	// Frame copy done: host sets, descriptor read clears
	// ************************************************************
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			frameCopyDone <= 1'b0;
		end else if (cmdWr && regWdata[`NCIR_CMD_FRAME_COPY_DONE]) begin
			frameCopyDone <= 1'b1;
		end else if (rxDescRead || (cmdWr && regTestMode)) begin
			frameCopyDone <= 1'b0;
		end
	end

	// ************************************************************
	// Descriptor pending bits: host sets, fetch or halt clears
	// ************************************************************
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rxDescPending <= 1'b0;
			txDescPending <= 1'b0;
		end else begin
			// Receive side
			if (rxQueueWr) begin
				rxDescPending <= 1'b1;
			end else if (rxHaltWr || rxDescHostOwned || (cmdWr && regTestMode)) begin
				rxDescPending <= 1'b0;
			end
			// Transmit side
			if (txQueueWr) begin
				txDescPending <= 1'b1;
			end else if (txHaltWr || txDescHostOwned || (cmdWr && regTestMode)) begin
				txDescPending <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Receiver online state, offline wins if both written
	// ************************************************************
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			receiverOnline <= 1'b0;
		end else if (cmdWr && regWdata[`NCIR_CMD_RECEIVER_OFFLINE]) begin
			receiverOnline <= 1'b0;
		end else if (cmdWr && regWdata[`NCIR_CMD_RECEIVER_ONLINE]) begin
			receiverOnline <= 1'b1;
		end
	end

	// ************************************************************
	// Interrupt mask, low sixteen bits only
	// ************************************************************
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			intMask <= `NCIR_RST_MASK;
		end else if (maskWr) begin
			intMask <= regWdata[`NCIR_MASK_BITS-1:0];
		end
	end

	// ************************************************************
	// Bus error flags: set wins over write-one clear
	// ************************************************************
	assign busErrSet = {evTargetAbort,
	                    evMasterAbort,
	                    evAddrParity && !busMaster && parityRespEn,
	                    evDataParity && busMaster && parityRespEn};

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			busErr <= `NCIR_RST_BUS_ERRORS;
		end else begin
			busErr <= busErrSet | (busErr & ~({`NCIR_BUS_ERRORS{stWr}} &
			          regWdata[`NCIR_ST_TARGET_ABORT:`NCIR_ST_DATA_PARITY]));
		end
	end

	// ************************************************************
	// Latched event flags 11..0
	// ************************************************************
	assign evSet = {evCopyThresh,
	                evEarlyRx,
	                evCounterNear,
	                evTxUnderrun,
	                txDescHostOwned,
	                evTxChainDone,
	                evTxFrameDone,
	                evRxCrc && !monitorMode,
	                evOverflow,
	                rxDescHostOwned,
	                evHeaderCopy,
	                evRxCopy};

	// Automatic clears from command writes, bit 12 position is not a flag here
	always_comb begin
		evClr = {`NCIR_LATCH_EVENTS{stWr}} & regWdata[`NCIR_LATCH_EVENTS-1:0];
		evClr[`NCIR_ST_TX_UNDERRUN]    = evClr[`NCIR_ST_TX_UNDERRUN] | restartWr;
		evClr[`NCIR_ST_TX_QUEUE_EMPTY] = evClr[`NCIR_ST_TX_QUEUE_EMPTY] | txQueueWr;
		evClr[`NCIR_ST_RX_QUEUE_EMPTY] = evClr[`NCIR_ST_RX_QUEUE_EMPTY] | rxQueueWr;
		next_evFlags = evSet | (evFlags & ~evClr);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			evFlags <= `NCIR_RST_EVENTS;
		end else begin
			evFlags <= next_evFlags;
		end
	end

	// ************************************************************
	// Pin event and wake event
	// ************************************************************
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			phyPinEvent <= 1'b0;
			wakeEvent   <= 1'b0;
		end else begin
			// Held set while the pin stays low
			if (gpio2Low) begin
				phyPinEvent <= 1'b1;
			end else if (stWr && regWdata[`NCIR_ST_PHY_PIN_EVENT]) begin
				phyPinEvent <= 1'b0;
			end
			// Status writes never touch the wake event
			if (wakeSet) begin
				wakeEvent <= 1'b1;
			end else if (wakeClear) begin
				wakeEvent <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Copy in progress flags
	// ************************************************************
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			txCopyActive <= 1'b0;
			rxCopyActive <= 1'b0;
		end else begin
			if (txCopyStart) begin
				txCopyActive <= 1'b1;
			end else if (txCopyPosted) begin
				txCopyActive <= 1'b0;
			end
			if (rxCopyStart) begin
				rxCopyActive <= 1'b1;
			end else if (rxCopyPosted) begin
				rxCopyActive <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Status summary and interrupt request
	// ************************************************************
	assign busErrorSummary = |busErr;
	assign statusLow = {phyPinEvent, wakeEvent, 1'b0, busErrorSummary, evFlags};
	assign irqPendingAny = |(statusLow & intMask);

	// Open drain line: drive low while enabled and pending
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			intaOe_n <= 1'b1;
		end else begin
			intaOe_n <= ~(intEnable && irqPendingAny);
		end
	end
	assign intaOut = 1'b0;

	// ************************************************************
	// Read views and read data register
	// ************************************************************
	assign cmdRead = {24'h00_0000, 3'h0, frameCopyDone, rxDescPending, txDescPending,
	                  receiverOnline, 1'b0};
	assign statusRead = {4'h0, busErr,
	                     rxStatusValid, copyThreshState, rxBufferEmpty,
	                     txCopyActive, rxCopyActive,
	                     transmit_quiet, receive_quiet,
	                     irqPendingAny, statusLow};
	assign maskRead = {16'h0000, intMask};

	always_comb begin
		case (regSel)
			NCIR_SEL_COMMAND: next_regRdata = cmdRead;
			NCIR_SEL_STATUS:  next_regRdata = statusRead;
			NCIR_SEL_MASK:    next_regRdata = maskRead;
			default:          next_regRdata = `NCIR_ZERO_WORD;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			regRdata <= `NCIR_ZERO_WORD;
		end else if (regRd) begin
			regRdata <= next_regRdata;
		end
	end

endmodule

// ===== common/ncir_consts.svh
// Register offsets, bit positions and reset values of the command and interrupt registers
`ifndef NCIR_CONSTS_SVH
`define NCIR_CONSTS_SVH

// ************************************************************
// Register offsets (byte addresses, dword access only)
// ************************************************************
`define NCIR_OFS_HOST_COMMAND     8'h00
`define NCIR_OFS_INTERRUPT_STATUS 8'h04
`define NCIR_OFS_INTERRUPT_MASK   8'h08

// ************************************************************
// Host command bit positions
// ************************************************************
`define NCIR_CMD_TX_RESTART_GO    7
`define NCIR_CMD_RX_DMA_HALT      6
`define NCIR_CMD_TX_DMA_HALT      5
`define NCIR_CMD_FRAME_COPY_DONE  4
`define NCIR_CMD_RX_DESC_PENDING  3
`define NCIR_CMD_TX_DESC_PENDING  2
`define NCIR_CMD_RECEIVER_ONLINE  1
`define NCIR_CMD_RECEIVER_OFFLINE 0

// ************************************************************
// Interrupt status bit positions
// ************************************************************
`define NCIR_ST_TARGET_ABORT      27
`define NCIR_ST_MASTER_ABORT      26
`define NCIR_ST_ADDR_PARITY       25
`define NCIR_ST_DATA_PARITY       24
`define NCIR_ST_RX_STATUS_VALID   23
`define NCIR_ST_COPY_THRESH_STATE 22
`define NCIR_ST_RX_BUFFER_EMPTY   21
`define NCIR_ST_TX_COPY_ACTIVE    20
`define NCIR_ST_RX_COPY_ACTIVE    19
`define NCIR_ST_TRANSMIT_QUIET    18
`define NCIR_ST_RECEIVE_QUIET     17
`define NCIR_ST_IRQ_PENDING_ANY   16
`define NCIR_ST_PHY_PIN_EVENT     15
`define NCIR_ST_WAKE_EVENT        14
`define NCIR_ST_BUS_ERROR_SUMMARY 12
`define NCIR_ST_TX_UNDERRUN       8
`define NCIR_ST_TX_QUEUE_EMPTY    7
`define NCIR_ST_RX_QUEUE_EMPTY    2

// ************************************************************
// Field widths and reset values
// ************************************************************
`define NCIR_LATCH_EVENTS         12
`define NCIR_MASK_BITS            16
`define NCIR_BUS_ERRORS           4
`define NCIR_RST_COMMAND          3'h0
`define NCIR_RST_MASK             16'h0000
`define NCIR_RST_EVENTS           12'h000
`define NCIR_RST_BUS_ERRORS       4'h0
`define NCIR_ZERO_WORD            32'h0000_0000

`endif

// ===== common/ncir_pkg.sv
// Shared types of the command and interrupt register block
package ncir_pkg;

	// One register data word
	typedef logic [31:0] ncir_word_t;

	// Register selected by the access address
	typedef enum logic [1:0] {
		NCIR_SEL_NONE    = 2'b00,
		NCIR_SEL_COMMAND = 2'b01,
		NCIR_SEL_STATUS  = 2'b10,
		NCIR_SEL_MASK    = 2'b11
	} ncir_sel_t;

endpackage

// ===== common/ncir_sync_if.sv
// Carrier between the pin synchroniser and the register block
`timescale 1ns/1ps
interface ncir_sync_if #(parameter int WIDTH = 1);
	logic [WIDTH-1:0] raw;     // Asynchronous pin levels
	logic [WIDTH-1:0] synced;  // Levels after two flip-flops
	modport sync (input raw, output synced);
	modport user (output raw, input synced);
endinterface

// ===== rtl/ncir_sync.sv
// Two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module ncir_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic  clk,
	input wire logic  sys_rst,
	// Pin levels in, synchronised levels out
	ncir_sync_if.sync port
);

	// First stage, read only by the second stage
	logic [WIDTH-1:0] stage1;
	// Second stage, safe to use
	logic [WIDTH-1:0] stage2;

	// ************************************************************
	// Synchroniser chain, resets to high (idle pin level)
	// ************************************************************
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			stage1 <= '1;
			stage2 <= '1;
		end else begin
			stage1 <= port.raw;
			stage2 <= stage1;
		end
	end

	assign port.synced = stage2;

endmodule

// ===== tb/ncir_regs_sva.sv
// Concurrent checks on the command and interrupt register ports
`timescale 1ns/1ps
module ncir_regs_sva (
	// Clock and reset
	input wire logic        clk,
	input wire logic        sys_rst,
	// Register access
	input wire logic [7:0]  regAddr,
	input wire logic        regWr,
	input wire logic        regRd,
	input wire logic [31:0] regWdata,
	input wire logic [31:0] regRdata,
	// Modes and events
	input wire logic        intEnable,
	input wire logic        rxDescRead,
	// Command and interrupt outputs
	input wire logic        transmitRestart,
	input wire logic        rxDmaHalt,
	input wire logic        txDmaHalt,
	input wire logic        frameCopyDone,
	input wire logic        rxDescPending,
	input wire logic        txDescPending,
	input wire logic        receiverOnline,
	input wire logic        intaOut,
	input wire logic        intaOe_n
);
	// ************************************************************
	// Write decode helpers
	// ************************************************************
	wire cmdWr     = regWr && regAddr == 8'h00;    // Command register write
	wire goRestart = cmdWr && regWdata[7];         // Restart request
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Halt write without a competing queue write, then its effect
	sequence sRxHalt; cmdWr && regWdata[6] && !regWdata[3]; endsequence
	sequence sRxHaltSeen; rxDmaHalt && !rxDescPending; endsequence
	a_restart_pulse: assert property (goRestart |=> transmitRestart)
		else $error("restart pulse missing");
	a_restart_cause: assert property (transmitRestart |-> $past(goRestart))
		else $error("restart pulse without request");
	a_rxhalt_clear: assert property (sRxHalt |=> sRxHaltSeen)
		else $error("receive halt wrong");
	a_txhalt_clear: assert property (cmdWr && regWdata[5] && !regWdata[2] |=>
		txDmaHalt && !txDescPending)
		else $error("transmit halt wrong");
	a_rxq_set: assert property (cmdWr && regWdata[3] |=> rxDescPending)
		else $error("receive queue not set");
	a_rx_online: assert property (cmdWr && regWdata[1] && !regWdata[0] |=> receiverOnline)
		else $error("receiver not online");
	a_rx_offline: assert property (cmdWr && regWdata[0] |=> !receiverOnline)
		else $error("receiver not offline");
	a_online_hold: assert property (!(cmdWr && regWdata[1:0] != 2'b00) |=>
		$stable(receiverOnline))
		else $error("receiver state changed alone");
	a_copy_done_clr: assert property (rxDescRead && !(cmdWr && regWdata[4]) |=>
		!frameCopyDone)
		else $error("copy done not cleared");
	a_inta_open: assert property (!intaOut)
		else $error("interrupt line not low driver");
	a_inta_off: assert property (!intEnable [*2] |-> intaOe_n)
		else $error("interrupt driven while disabled");
	a_cmd_read: assert property (regRd && regAddr == 8'h00 |=>
		regRdata[31:5] == 27'h0 && !regRdata[0])
		else $error("command read shows one-shot bits");
endmodule

// ===== tb/ncir_host.sv
// Host driver model issuing register accesses
`timescale 1ns/1ps
module ncir_host (
	// Clock
	input  wire logic        clk,
	// Register access
	output logic [7:0]       regAddr,
	output logic             regWr,
	output logic             regRd,
	output logic [31:0]      regWdata,
	input  wire logic [31:0] regRdata
);
	// Idle bus at time zero
	initial begin
		regAddr = 8'h00;
		regWr = 1'b0;
		regRd = 1'b0;
		regWdata = 32'h0000_0000;
	end
	// One write, launched and dropped on falling edges
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge clk);
		regAddr = a;
		regWdata = (a == 8'h00) ? (d & 32'h0000_00FF) : d;
		regWr = 1'b1;
		@(negedge clk);
		regWr = 1'b0;
		regWdata = ~regWdata;
	endtask
	// One read, data taken once the strobe edge has passed
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(negedge clk);
		regAddr = a;
		regRd = 1'b1;
		@(negedge clk);
		regRd = 1'b0;
		d = regRdata;
	endtask
endmodule

// ===== tb/ncir_regs_tb_top.sv
// Self-checking bench of the command and interrupt registers
`timescale 1ns/1ps
module ncir_regs_tb_top import ncir_pkg::*; ();
	// ************************************************************
	// Stimulus and observed signals
	// ************************************************************
	logic        clk = 1'b0;          // 200 MHz clock
	logic        sys_rst = 1'b1;      // Synchronous reset
	logic        regTestMode = 1'b0;  // Register test mode
	logic        intEnable = 1'b0;    // Global interrupt enable
	logic        parityRespEn = 1'b0; // Parity response
	logic        busMaster = 1'b0;    // Device owns the bus
	logic        monitorMode = 1'b0;  // Crc errors not flagged while set
	logic        gpio2Pin = 1'b1;     // Pin idles high
	logic [22:0] pv = '0;             // Event pulses
	logic [4:0]  lv = '0;             // State levels
	logic [7:0]  regAddr;
	logic        regWr, regRd;
	ncir_word_t  regWdata, regRdata;
	logic        tRst, rHalt, tHalt, fcd, rxp, txp, onl, intaOut, intaOe_n;
	int          num_errors = 0;
	int          compares = 0;
	int          evPos[10] = '{11, 10, 9, 8, 6, 5, 4, 3, 1, 0};
	// Clock
	always #2.5 clk = ~clk;
	ncir_host ncir_host_inst (.clk(clk), .regAddr(regAddr), .regWr(regWr), .regRd(regRd),
		.regWdata(regWdata), .regRdata(regRdata));
	ncir_regs ncir_regs_inst (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWr(regWr),
		.regRd(regRd), .regWdata(regWdata), .regRdata(regRdata), .regTestMode(regTestMode),
		.intEnable(intEnable), .parityRespEn(parityRespEn), .monitorMode(monitorMode),
		.rxDescRead(pv[12]), .rxDescHostOwned(pv[11]), .txDescHostOwned(pv[10]),
		.evTargetAbort(pv[9]), .evMasterAbort(pv[8]), .evAddrParity(pv[7]),
		.evDataParity(pv[6]), .busMaster(busMaster), .rxStatusValid(lv[4]),
		.copyThreshState(lv[3]), .rxBufferEmpty(lv[2]), .transmit_quiet(lv[1]), .receive_quiet(lv[0]),
		.txCopyStart(pv[5]), .txCopyPosted(pv[4]), .rxCopyStart(pv[3]), .rxCopyPosted(pv[2]),
		.wakeSet(pv[1]), .wakeClear(pv[0]), .gpio2Pin(gpio2Pin), .evCopyThresh(pv[22]),
		.evEarlyRx(pv[21]), .evCounterNear(pv[20]), .evTxUnderrun(pv[19]),
		.evTxChainDone(pv[18]), .evTxFrameDone(pv[17]), .evRxCrc(pv[16]),
		.evOverflow(pv[15]), .evHeaderCopy(pv[14]), .evRxCopy(pv[13]),
		.transmitRestart(tRst), .rxDmaHalt(rHalt), .txDmaHalt(tHalt), .frameCopyDone(fcd),
		.rxDescPending(rxp), .txDescPending(txp), .receiverOnline(onl),
		.intaOut(intaOut), .intaOe_n(intaOe_n));
	// ************************************************************
	// Shared helpers
	// ************************************************************
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input ncir_word_t d);
		ncir_host_inst.wr(a, d);
	endtask
	task automatic rc(input logic [7:0] a, input ncir_word_t e);
		ncir_word_t g;
		ncir_host_inst.rd(a, g);
		chk($sformatf("register %h", a), e, g);
	endtask
	// One-cycle event pulse
	task automatic fire(input logic [22:0] m);
		@(negedge clk) pv = m;
		@(negedge clk) pv = '0;
	endtask
	task conclude();
		$display("Comparisons %0d, mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_reset();
		rc(8'h00, 32'h0);
		rc(8'h04, 32'h0);
		rc(8'h08, 32'h0);
		rc(8'h0C, 32'h0);
		wr(8'h08, 32'hFFFF_FFFF);
		rc(8'h08, 32'h0000_FFFF);
		wr(8'h08, 32'h0);
	endtask
	task automatic t_command();
		wr(8'h00, 32'h0C);
		chk("descPending", 32'h3, {rxp, txp});
		rc(8'h00, 32'h0C);
		fire(23'h000800);
		rc(8'h00, 32'h04);
		rc(8'h04, 32'h04);
		wr(8'h04, 32'h04);
		rc(8'h00, 32'h04);
		wr(8'h00, 32'h08);
		fire(23'h000400);
		rc(8'h04, 32'h80);
		rc(8'h00, 32'h08);
		wr(8'h00, 32'h04);
		rc(8'h04, 32'h0);
		wr(8'h00, 32'h40);
		chk("rxDmaHalt", 32'h1, rHalt);
		wr(8'h00, 32'h20);
		chk("txDmaHalt", 32'h1, tHalt);
		rc(8'h00, 32'h0);
		fire(23'h080000);
		wr(8'h00, 32'h80);
		chk("transmitRestart", 32'h1, tRst);
		rc(8'h04, 32'h0);
		wr(8'h00, 32'h02);
		wr(8'h00, 32'h00);
		rc(8'h00, 32'h02);
		wr(8'h00, 32'h01);
		chk("receiverOnline", 32'h0, onl);
		wr(8'h00, 32'h10);
		wr(8'h00, 32'h00);
		chk("frameCopyDone", 32'h1, fcd);
		fire(23'h001000);
		chk("frameCopyDone", 32'h0, fcd);
		@(negedge clk) regTestMode = 1'b1;
		wr(8'h00, 32'h1C);
		wr(8'h00, 32'h00);
		rc(8'h00, 32'h0);
		@(negedge clk) regTestMode = 1'b0;
	endtask
	task automatic t_events();
		for (int i = 0; i < 10; i++) begin
			fire(23'h1 << (22 - i));
			rc(8'h04, 32'h1 << evPos[i]);
			wr(8'h04, 32'h1 << evPos[i]);
			rc(8'h04, 32'h0);
		end
		@(negedge clk) monitorMode = 1'b1;
		fire(23'h010000);
		rc(8'h04, 32'h0);
		@(negedge clk) monitorMode = 1'b0;
	endtask
	task automatic t_bus();
		fire(23'h000080);
		rc(8'h04, 32'h0);
		@(negedge clk) parityRespEn = 1'b1;
		fire(23'h000080);
		rc(8'h04, 32'h0200_1000);
		@(negedge clk) busMaster = 1'b1;
		fire(23'h000040);
		fire(23'h000300);
		rc(8'h04, 32'h0F00_1000);
		wr(8'h04, 32'h0F00_0000);
		rc(8'h04, 32'h0);
	endtask
	task automatic t_levels();
		@(negedge clk) lv = 5'h1F;
		rc(8'h04, 32'h00E6_0000);
		fire(23'h000028);
		wr(8'h04, 32'hFFFF_0000);
		rc(8'h04, 32'h00FE_0000);
		fire(23'h000014);
		rc(8'h04, 32'h00E6_0000);
		@(negedge clk) lv = 5'h00;
		fire(23'h000002);
		wr(8'h04, 32'h4000);
		rc(8'h04, 32'h4000);
		fire(23'h000001);
		rc(8'h04, 32'h0);
	endtask
	task automatic t_irq();
		wr(8'h08, 32'h1);
		@(negedge clk) intEnable = 1'b1;
		fire(23'h002000);
		rc(8'h04, 32'h0001_0001);
		chk("intaOe_n", 32'h0, intaOe_n);
		wr(8'h08, 32'h0);
		rc(8'h04, 32'h0000_0001);
		chk("intaOe_n", 32'h1, intaOe_n);
		wr(8'h08, 32'h1);
		@(negedge clk) intEnable = 1'b0;
		rc(8'h04, 32'h0001_0001);
		chk("intaOe_n", 32'h1, intaOe_n);
		wr(8'h04, 32'h1);
		@(negedge clk) gpio2Pin = 1'b0;
		repeat (4) @(negedge clk);
		gpio2Pin = 1'b1;
		rc(8'h04, 32'h8000);
		wr(8'h04, 32'h8000);
		rc(8'h04, 32'h0);
	endtask
	// Main sequence
	initial begin
		repeat (8) @(negedge clk);
		sys_rst = 1'b0;
		t_reset();
		t_command();
		t_events();
		t_bus();
		t_levels();
		t_irq();
		conclude();
	end
	// Watchdog against a hang
	initial begin
		repeat (4000) @(posedge clk);
		num_errors++;
		conclude();
	end
endmodule
bind ncir_regs ncir_regs_sva ncir_regs_sva_inst (.clk(clk), .sys_rst(sys_rst),
	.regAddr(regAddr), .regWr(regWr), .regRd(regRd), .regWdata(regWdata),
	.regRdata(regRdata), .intEnable(intEnable), .rxDescRead(rxDescRead),
	.transmitRestart(transmitRestart), .rxDmaHalt(rxDmaHalt), .txDmaHalt(txDmaHalt),
	.frameCopyDone(frameCopyDone), .rxDescPending(rxDescPending),
	.txDescPending(txDescPending), .receiverOnline(receiverOnline),
	.intaOut(intaOut), .intaOe_n(intaOe_n));
